// ### rtl/epmc_regs.svh
// Constants for the erasable PROM mode controller: widths, codes and timing.
// Assumes a single 125 MHz clock; all times are in nanoseconds.
`ifndef EPMC_REGS_SVH
`define EPMC_REGS_SVH

`define EPMC_ADDR_W       18
`define EPMC_DATA_W       8
`define EPMC_TMR_W        16
`define EPMC_FIRST_ADDR   18'h00000
`define EPMC_LAST_ADDR    18'h3FFFF
`define EPMC_ADDR_STEP    18'h00001
`define EPMC_IDENT_HIGH   17'h00000
`define EPMC_ERASED       8'hFF
`define EPMC_CLK_MHZ      125
`define EPMC_NS_PER_US    1000
`define EPMC_T_SETUP_NS   2000
`define EPMC_T_PULSE_NS   100000
`define EPMC_T_ACCESS_NS  120
`define EPMC_T_VERIFY_NS  150
`define EPMC_SYNC_STAGES  2
`define EPMC_TMR_LAST     16'h0001

`endif

// ### rtl/epmc_pkg.sv
// Types shared by the erasable PROM mode controller modules.
// Assumes epmc_regs.svh is on the include path.
`include "epmc_regs.svh"

package epmc_pkg;

    typedef enum logic [1:0] {
        OP_READ    = 2'h0,
        OP_PROGRAM = 2'h1,
        OP_ERASE   = 2'h2,
        OP_IDENT   = 2'h3
    } epmc_op_t;

    // Gray codes along the usual path
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_SETUP  = 4'h1,
        ST_STROBE = 4'h3,
        ST_HOLD   = 4'h2,
        ST_TURN   = 4'h6,
        ST_VWAIT  = 4'h7,
        ST_CHECK  = 4'h5,
        ST_FINISH = 4'h4
    } epmc_state_t;

    typedef struct packed {
        logic                      valid;
        epmc_op_t                  op;
        logic [`EPMC_ADDR_W-1:0]   addr;
        logic [`EPMC_DATA_W-1:0]   data;
    } epmc_req_t;

    typedef struct packed {
        logic                      done;
        logic                      fail;
        logic [`EPMC_DATA_W-1:0]   data;
    } epmc_rsp_t;

    typedef struct packed {
        epmc_state_t               st;
        epmc_op_t                  op;
        logic [`EPMC_ADDR_W-1:0]   addr;
        logic [`EPMC_DATA_W-1:0]   data;
        logic [`EPMC_DATA_W-1:0]   lane;
        logic                      lane_oe;
        logic                      ce_n;
        logic                      oe_n;
        logic                      we_n;
        logic                      prog_sup;
        logic                      erase_sup;
        logic                      core_prog;
        logic                      erase_a9;
        logic                      ident_a9;
        logic [`EPMC_DATA_W-1:0]   sync1;
        logic [`EPMC_DATA_W-1:0]   sync2;
        logic                      tstart;
        logic [`EPMC_TMR_W-1:0]    tload;
        logic                      ready;
        epmc_rsp_t                 rsp;
    } epmc_host_state_t;

    typedef struct packed {
        logic [`EPMC_TMR_W-1:0]    cnt;
        logic                      done;
    } epmc_timer_state_t;

    // Least time rounded up to whole cycles, never below one
    function automatic int epmc_cycles(input int ns);
        int c;
        c = (ns * `EPMC_CLK_MHZ + `EPMC_NS_PER_US - 1) / `EPMC_NS_PER_US;
        return (c < 1) ? 1 : c;
    endfunction

endpackage

// ### rtl/epmc_timer.sv
// Interval timer: loads a cycle count and pulses done once it has elapsed.
// Assumes start is a one-cycle pulse from logic on the same clock.
`include "epmc_regs.svh"

module epmc_timer (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    start_i,
    input  wire logic [`EPMC_TMR_W-1:0]  count_i,
    output logic                         done_o
);

    epmc_pkg::epmc_timer_state_t s;
    epmc_pkg::epmc_timer_state_t n;

    always_comb begin
        n      = s;
        n.done = 1'b0;
        if (start_i) begin
            n.cnt = count_i;
        end else if (s.cnt == `EPMC_TMR_LAST) begin
            n.cnt  = '0;
            n.done = 1'b1;
        end else if (s.cnt != '0) begin
            n.cnt = s.cnt - `EPMC_TMR_LAST;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign done_o = s.done;

endmodule // epmc_timer

// ### rtl/epmc_host.sv
// Host controller for a 256K x 8 electrically erasable PROM: read, identifier
// readout, byte program with verify, whole-chip erase with erase verify that stops at the first byte not reading FF.
// Assumes board drivers turn the level qualifier outputs into real supplies
// and that the byte lane wire is resolved outside from LANE_O and LANE_OE_O.
`include "epmc_regs.svh"

// Contract
// [RL1] Array is 262144 bytes, 18-bit address, one shared bidirectional byte lane.
// [RL2] Chip select and output gate low make the device drive the addressed byte.
// [RL3] Output gate high keeps the device lane floating, so host may drive it.
// [RL4] Chip select high puts the device in standby with outputs floating.
// [RL5] Erase entry: 14V supply, address nine high level, bit zero low, data all ones.
// [RL6] Low strobe pulse under erase conditions starts whole-chip erase.
// [RL7] Only erase makes ones; erased locations read FF.
// [RL8] 14V supply, select and gate low, strobe high gives erase verify.
// [RL9] Host reads every byte in erase verify and expects FF; the code ends the walk at the first byte that does not read FF.
// [RL10] Program: 12V supply, select low, gate high, address and data, strobe low.
// [RL11] Programming only turns ones into zeros.
// [RL12] 12V supply, select and gate low, strobe high gives program verify.
// [RL13] Host verifies each byte right after programming it.
// [RL14] Select high makes the device ignore erase and program conditions.
// [RL15] Address nine at identifier level gives ID byte; address bit zero picks which.
// [RL16] Elevated supply and address levels are separate digital qualifier outputs.
module epmc_host #(
    parameter int PULSE_CYCLES = epmc_pkg::epmc_cycles(`EPMC_T_PULSE_NS)
) (
    input  wire logic                     MCLK_I,
    input  wire logic                     RST_I,
    input  wire epmc_pkg::epmc_req_t      REQ_I,
    output logic                          READY_O,
    output epmc_pkg::epmc_rsp_t           RSP_O,
    output logic [`EPMC_ADDR_W-1:0]       BYTE_ADDRESS_O,
    output logic [`EPMC_DATA_W-1:0]       BYTE_LANE_O,
    output logic                          BYTE_LANE_OE_O,
    input  wire logic [`EPMC_DATA_W-1:0]  BYTE_LANE_I,
    output logic                          CHIP_SELECT_N_O,
    output logic                          OUTPUT_GATE_N_O,
    output logic                          WRITE_STROBE_N_O,
    output logic                          PROGRAM_SUPPLY_LEVEL_O,
    output logic                          ERASE_SUPPLY_LEVEL_O,
    output logic                          CORE_SUPPLY_PROGRAM_LEVEL_O,
    output logic                          ERASE_ADDRESS_LEVEL_O,
    output logic                          IDENTIFIER_ADDRESS_LEVEL_O
);

    localparam logic [`EPMC_TMR_W-1:0] SETUP_CYC  = `EPMC_TMR_W'(epmc_pkg::epmc_cycles(`EPMC_T_SETUP_NS));
    localparam logic [`EPMC_TMR_W-1:0] PULSE_CYC  = `EPMC_TMR_W'(PULSE_CYCLES);
    // Sync stages added so the sampled byte has settled through both flops
    localparam logic [`EPMC_TMR_W-1:0] READ_CYC   =
        `EPMC_TMR_W'(epmc_pkg::epmc_cycles(`EPMC_T_ACCESS_NS) + `EPMC_SYNC_STAGES);
    localparam logic [`EPMC_TMR_W-1:0] VERIFY_CYC =
        `EPMC_TMR_W'(epmc_pkg::epmc_cycles(`EPMC_T_VERIFY_NS) + `EPMC_SYNC_STAGES);

    localparam epmc_pkg::epmc_host_state_t RESET_S = '{
        st:      epmc_pkg::ST_IDLE,
        op:      epmc_pkg::OP_READ,
        ce_n:    1'b1,
        oe_n:    1'b1,
        we_n:    1'b1,
        ready:   1'b1,
        default: '0
    };

    epmc_pkg::epmc_host_state_t s;
    epmc_pkg::epmc_host_state_t n;
    logic                       tdone;

    epmc_timer u_timer (
        .clk_i   (MCLK_I),
        .rst_i   (RST_I),
        .start_i (s.tstart),
        .count_i (s.tload),
        .done_o  (tdone)
    );

    always_comb begin
        n          = s;
        n.tstart   = 1'b0;
        n.rsp.done = 1'b0;
        n.sync1    = BYTE_LANE_I;
        n.sync2    = s.sync1;
        case (s.st)
            epmc_pkg::ST_IDLE: begin
                if (REQ_I.valid) begin
                    n.ready    = 1'b0;
                    n.rsp.fail = 1'b0;
                    n.op       = REQ_I.op;
                    n.data     = REQ_I.data;
                    n.ce_n     = 1'b0;
                    n.tstart   = 1'b1;
                    n.tload    = SETUP_CYC;
                    n.st       = epmc_pkg::ST_SETUP;
                    case (REQ_I.op)
                        epmc_pkg::OP_READ: begin
                            n.addr  = REQ_I.addr;
                            n.oe_n  = 1'b0; // see [RL2]
                            n.tload = READ_CYC;
                            n.st    = epmc_pkg::ST_VWAIT;
                        end
                        epmc_pkg::OP_IDENT: begin
                            n.addr     = {`EPMC_IDENT_HIGH, REQ_I.addr[0]}; // see [RL15]
                            n.ident_a9 = 1'b1; // see [RL16]
                        end
                        epmc_pkg::OP_PROGRAM: begin
                            n.addr      = REQ_I.addr; // see [RL10]
                            n.prog_sup  = 1'b1; // see [RL16]
                            n.core_prog = 1'b1;
                            n.lane      = REQ_I.data;
                            n.lane_oe   = 1'b1; // see [RL3]
                        end
                        default: begin
                            n.addr      = `EPMC_FIRST_ADDR; // see [RL5]
                            n.erase_sup = 1'b1;
                            n.erase_a9  = 1'b1;
                            n.core_prog = 1'b1;
                            n.lane      = `EPMC_ERASED;
                            n.lane_oe   = 1'b1;
                            n.data      = `EPMC_ERASED; // see [RL7]
                        end
                    endcase
                end
            end
            epmc_pkg::ST_SETUP: begin
                if (tdone) begin
                    n.tstart = 1'b1;
                    if (s.op == epmc_pkg::OP_IDENT) begin
                        n.oe_n  = 1'b0;
                        n.tload = READ_CYC;
                        n.st    = epmc_pkg::ST_VWAIT;
                    end else begin
                        n.we_n  = 1'b0; // see [RL6] see [RL10]
                        n.tload = PULSE_CYC;
                        n.st    = epmc_pkg::ST_STROBE;
                    end
                end
            end
            epmc_pkg::ST_STROBE: begin
                if (tdone) begin
                    n.we_n   = 1'b1;
                    n.tstart = 1'b1;
                    n.tload  = SETUP_CYC;
                    n.st     = epmc_pkg::ST_HOLD;
                end
            end
            epmc_pkg::ST_HOLD: begin
                // Data and address held past strobe rise before the lane turns round
                if (tdone) begin
                    n.lane_oe  = 1'b0;
                    n.erase_a9 = 1'b0;
                    n.tstart   = 1'b1;
                    n.tload    = SETUP_CYC;
                    n.st       = epmc_pkg::ST_TURN;
                end
            end
            epmc_pkg::ST_TURN: begin
                if (tdone) begin
                    n.oe_n   = 1'b0; // see [RL8] see [RL12]
                    n.tstart = 1'b1;
                    n.tload  = VERIFY_CYC;
                    n.st     = epmc_pkg::ST_VWAIT;
                end
            end
            epmc_pkg::ST_VWAIT: begin
                if (tdone) begin
                    n.st = epmc_pkg::ST_CHECK;
                end
            end
            epmc_pkg::ST_CHECK: begin
                n.rsp.data = s.sync2;
                n.st       = epmc_pkg::ST_FINISH;
                if (s.op == epmc_pkg::OP_PROGRAM || s.op == epmc_pkg::OP_ERASE) begin
                    if (s.sync2 != s.data) begin
                        n.rsp.fail = 1'b1; // see [RL13] see [RL9]
                    end else if (s.op == epmc_pkg::OP_ERASE && s.addr != `EPMC_LAST_ADDR) begin
                        // Walks all 262144 bytes unless one fails, which ends the walk; a full pass takes about 50 ms
                        n.addr   = s.addr + `EPMC_ADDR_STEP; // see [RL9] see [RL1]
                        n.tstart = 1'b1;
                        n.tload  = VERIFY_CYC;
                        n.st     = epmc_pkg::ST_VWAIT;
                    end
                end
            end
            epmc_pkg::ST_FINISH: begin
                n          = RESET_S; // see [RL4] see [RL14]
                n.sync1    = BYTE_LANE_I;
                n.sync2    = s.sync1;
                n.rsp      = s.rsp;
                n.rsp.done = 1'b1;
            end
            default: begin
                n = RESET_S;
            end
        endcase
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            s <= RESET_S;
        end else begin
            s <= n;
        end
    end

    assign READY_O                     = s.ready;
    assign RSP_O                       = s.rsp;
    assign BYTE_ADDRESS_O              = s.addr;
    assign BYTE_LANE_O                 = s.lane;
    assign BYTE_LANE_OE_O              = s.lane_oe;
    assign CHIP_SELECT_N_O             = s.ce_n;
    assign OUTPUT_GATE_N_O             = s.oe_n;
    assign WRITE_STROBE_N_O            = s.we_n;
    assign PROGRAM_SUPPLY_LEVEL_O      = s.prog_sup;
    assign ERASE_SUPPLY_LEVEL_O        = s.erase_sup;
    assign CORE_SUPPLY_PROGRAM_LEVEL_O = s.core_prog;
    assign ERASE_ADDRESS_LEVEL_O       = s.erase_a9;
    assign IDENTIFIER_ADDRESS_LEVEL_O  = s.ident_a9;

endmodule // epmc_host

// ### bench/epmc_host_properties.sv
// Pin-level properties of the PROM host controller.
// Assumes it is bound to epmc_host and sees only that module's ports.
`include "epmc_regs.svh"
module epmc_host_properties #(
    parameter int PULSE_CYCLES = 20
) (
    input wire logic                     MCLK_I,
    input wire logic                     RST_I,
    input wire epmc_pkg::epmc_req_t      REQ_I,
    input wire logic                     READY_O,
    input wire epmc_pkg::epmc_rsp_t      RSP_O,
    input wire logic [`EPMC_ADDR_W-1:0]  BYTE_ADDRESS_O,
    input wire logic [`EPMC_DATA_W-1:0]  BYTE_LANE_O,
    input wire logic                     BYTE_LANE_OE_O,
    input wire logic [`EPMC_DATA_W-1:0]  BYTE_LANE_I,
    input wire logic                     CHIP_SELECT_N_O,
    input wire logic                     OUTPUT_GATE_N_O,
    input wire logic                     WRITE_STROBE_N_O,
    input wire logic                     PROGRAM_SUPPLY_LEVEL_O,
    input wire logic                     ERASE_SUPPLY_LEVEL_O,
    input wire logic                     CORE_SUPPLY_PROGRAM_LEVEL_O,
    input wire logic                     ERASE_ADDRESS_LEVEL_O,
    input wire logic                     IDENTIFIER_ADDRESS_LEVEL_O
);
    timeunit 1ns;
    timeprecision 1ps;
    int low_cnt;
    // Counter, since the pulse is far too long for a repetition
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) low_cnt <= 0;
        else if (!WRITE_STROBE_N_O) low_cnt <= low_cnt + 1;
        else low_cnt <= 0;
    end
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    strobe_width_a: assert property ($rose(WRITE_STROBE_N_O) |-> low_cnt >= PULSE_CYCLES
        && low_cnt <= PULSE_CYCLES + 2)
        else $error("strobe width wrong");
    lane_contention_a: assert property (BYTE_LANE_OE_O |-> OUTPUT_GATE_N_O)
        else $error("host drives lane with gate low");
    idle_pins_a: assert property (READY_O && $past(READY_O) |-> CHIP_SELECT_N_O && OUTPUT_GATE_N_O
        && !BYTE_LANE_OE_O)
        else $error("pins not idle while ready");
    strobe_cond_a: assert property (!WRITE_STROBE_N_O |-> !CHIP_SELECT_N_O && OUTPUT_GATE_N_O
        && BYTE_LANE_OE_O && CORE_SUPPLY_PROGRAM_LEVEL_O && (PROGRAM_SUPPLY_LEVEL_O != ERASE_SUPPLY_LEVEL_O))
        else $error("strobe without write conditions");
    erase_entry_a: assert property (!WRITE_STROBE_N_O && ERASE_SUPPLY_LEVEL_O |-> ERASE_ADDRESS_LEVEL_O
        && BYTE_ADDRESS_O == 18'h00000 && BYTE_LANE_O == 8'hFF)
        else $error("erase entry conditions wrong");
    strobe_stable_a: assert property ((!WRITE_STROBE_N_O) [*2] |-> $stable(BYTE_ADDRESS_O)
        && $stable(BYTE_LANE_O))
        else $error("address or data moved under strobe");
    verify_read_a: assert property (!OUTPUT_GATE_N_O |-> !CHIP_SELECT_N_O && WRITE_STROBE_N_O
        && !ERASE_ADDRESS_LEVEL_O)
        else $error("gate low outside a read");
    ident_addr_a: assert property (IDENTIFIER_ADDRESS_LEVEL_O |-> BYTE_ADDRESS_O[17:1] == 17'h00000
        && !PROGRAM_SUPPLY_LEVEL_O && !ERASE_SUPPLY_LEVEL_O)
        else $error("identifier readout conditions wrong");
    done_pulse_a: assert property (RSP_O.done |-> READY_O ##1 !RSP_O.done)
        else $error("done not a single ready pulse");
    program_c: cover property (!WRITE_STROBE_N_O && PROGRAM_SUPPLY_LEVEL_O);
    erase_c: cover property (!WRITE_STROBE_N_O && ERASE_SUPPLY_LEVEL_O);
    ident_c: cover property (IDENTIFIER_ADDRESS_LEVEL_O && !OUTPUT_GATE_N_O);
    fail_c: cover property (RSP_O.done && RSP_O.fail);
endmodule // epmc_host_properties

bind epmc_host epmc_host_properties #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (.MCLK_I(MCLK_I), .RST_I(RST_I),
    .REQ_I(REQ_I), .READY_O(READY_O), .RSP_O(RSP_O), .BYTE_ADDRESS_O(BYTE_ADDRESS_O), .BYTE_LANE_O(BYTE_LANE_O),
    .BYTE_LANE_OE_O(BYTE_LANE_OE_O), .BYTE_LANE_I(BYTE_LANE_I), .CHIP_SELECT_N_O(CHIP_SELECT_N_O),
    .OUTPUT_GATE_N_O(OUTPUT_GATE_N_O), .WRITE_STROBE_N_O(WRITE_STROBE_N_O),
    .PROGRAM_SUPPLY_LEVEL_O(PROGRAM_SUPPLY_LEVEL_O), .ERASE_SUPPLY_LEVEL_O(ERASE_SUPPLY_LEVEL_O),
    .CORE_SUPPLY_PROGRAM_LEVEL_O(CORE_SUPPLY_PROGRAM_LEVEL_O), .ERASE_ADDRESS_LEVEL_O(ERASE_ADDRESS_LEVEL_O),
    .IDENTIFIER_ADDRESS_LEVEL_O(IDENTIFIER_ADDRESS_LEVEL_O));

// ### bench/epmc_prom_model.sv
// Behavioural PROM: sparse array, mode decode from pins and level qualifiers.
// Assumes the bench resolves the shared lane; erase leaves WEAK_ADDR at zero.
module epmc_prom_model #(
    parameter logic [7:0]  MFR_CODE  = 8'h3C, // Arbitrary identity value
    parameter logic [7:0]  DEV_CODE  = 8'hA7, // Arbitrary identity value
    parameter logic [17:0] WEAK_ADDR = 18'h00005
) (
    input  wire logic [17:0] addr_i,
    input  wire logic [7:0]  lane_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        prog_sup_i,
    input  wire logic        erase_sup_i,
    input  wire logic        core_prog_i,
    input  wire logic        erase_a9_i,
    input  wire logic        ident_a9_i,
    output logic [7:0]       lane_o,
    output logic             lane_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [int]; // Blank cells read FF
    int         wr_cnt = 0;
    assign lane_oe_o = !ce_n_i && !oe_n_i;
    // wr_cnt retriggers the read path after a write at the same address
    always @(addr_i or ident_a9_i or prog_sup_i or erase_sup_i or wr_cnt) begin
        if (ident_a9_i && !prog_sup_i && !erase_sup_i) lane_o = addr_i[0] ? DEV_CODE : MFR_CODE;
        else lane_o = mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 8'hFF;
    end
    always @(posedge we_n_i) begin
        if (!ce_n_i && oe_n_i && core_prog_i) begin
            if (erase_sup_i && erase_a9_i && addr_i == 18'h00000 && lane_i == 8'hFF) begin
                mem.delete();
                mem[int'(WEAK_ADDR)] = 8'h00;
            end else if (prog_sup_i && !erase_sup_i) begin
                mem[int'(addr_i)] = lane_i & (mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 8'hFF);
            end
            wr_cnt++;
        end
    end
endmodule // epmc_prom_model

// ### bench/epmc_host_tb_top.sv
// Self-checking bench: host controller against a behavioural PROM.
// Assumes the rtl package, header and checker are compiled first.
`include "epmc_regs.svh"
module epmc_host_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0]  MFR  = 8'h3C; // Arbitrary identity value
    localparam logic [7:0]  DEV  = 8'hA7; // Arbitrary identity value
    localparam logic [17:0] WEAK = 18'h00005;
    logic mclk = 0, rst = 1, rdy, loe, ce_n, oe_n, we_n, psup, esup, core, ea9, ia9, doe;
    epmc_pkg::epmc_req_t req = '0;
    epmc_pkg::epmc_rsp_t rsp;
    logic [17:0] addr, a, list [3];
    logic [7:0] hl, dl, lane, d1, d2, last = 8'h00;
    logic [7:0] mem [int];
    int error_cnt = 0, cmp_count = 0, cyc = 0, seed = 32'hd136;
    // A floating lane flips every cycle so stale data cannot pass
    assign lane = loe ? hl : doe ? dl : ~last;
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        last <= lane;
        cyc <= cyc + 1;
        if (cyc > 30000) begin
            error_cnt++;
            end_of_test();
        end
    end
    epmc_host #(.PULSE_CYCLES(20)) DUT (.MCLK_I(mclk), .RST_I(rst), .REQ_I(req), .READY_O(rdy), .RSP_O(rsp),
        .BYTE_ADDRESS_O(addr), .BYTE_LANE_O(hl), .BYTE_LANE_OE_O(loe), .BYTE_LANE_I(lane), .CHIP_SELECT_N_O(ce_n),
        .OUTPUT_GATE_N_O(oe_n), .WRITE_STROBE_N_O(we_n), .PROGRAM_SUPPLY_LEVEL_O(psup), .ERASE_SUPPLY_LEVEL_O(esup),
        .CORE_SUPPLY_PROGRAM_LEVEL_O(core), .ERASE_ADDRESS_LEVEL_O(ea9), .IDENTIFIER_ADDRESS_LEVEL_O(ia9));
    epmc_prom_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .WEAK_ADDR(WEAK)) u_prom (.addr_i(addr), .lane_i(lane),
        .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .prog_sup_i(psup), .erase_sup_i(esup), .core_prog_i(core),
        .erase_a9_i(ea9), .ident_a9_i(ia9), .lane_o(dl), .lane_oe_o(doe));
    task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(string nm, logic e, logic g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask
    function automatic logic [7:0] peek(logic [17:0] x);
        return mem.exists(int'(x)) ? mem[int'(x)] : 8'hFF;
    endfunction
    task automatic run(epmc_pkg::epmc_op_t op, logic [17:0] x, logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        req <= '{1'b1, op, x, d};
        @(posedge mclk);
        req.valid <= 1'b0;
        do begin
            @(negedge mclk);
            n++;
        end while (rsp.done !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            error_cnt++;
            end_of_test();
        end
    endtask
    task end_of_test;
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk1("ready after reset", 1'b1, rdy);
        for (int i = 0; i < 2; i++) begin
            run(epmc_pkg::OP_IDENT, 18'(i), 8'h00);
            chk8("ident", (i == 1) ? DEV : MFR, rsp.data);
        end
        a = 18'($random(seed)) | 18'h00010;
        d1 = 8'($random(seed)) & 8'h7F;
        d2 = ~d1;
        run(epmc_pkg::OP_PROGRAM, a, d1);
        mem[int'(a)] = d1;
        chk1("program fail", 1'b0, rsp.fail);
        chk8("program readback", d1, rsp.data);
        run(epmc_pkg::OP_PROGRAM, a, d2);
        mem[int'(a)] = d1 & d2;
        chk1("reprogram fail", (d1 & d2) != d2, rsp.fail);
        chk8("reprogram readback", d1 & d2, rsp.data);
        run(epmc_pkg::OP_READ, a ^ 18'h20000, 8'h00);
        chk8("blank read", peek(a ^ 18'h20000), rsp.data);
        run(epmc_pkg::OP_ERASE, 18'h00000, 8'hFF);
        mem.delete();
        mem[int'(WEAK)] = 8'h00;
        chk1("erase fail", 1'b1, rsp.fail);
        chk8("erase last byte", 8'h00, rsp.data);
        list = '{a, WEAK, 18'h3FFFF};
        foreach (list[i]) begin
            run(epmc_pkg::OP_READ, list[i], 8'h00);
            chk8("read after erase", peek(list[i]), rsp.data);
        end
        end_of_test();
    end
endmodule // epmc_host_tb_top
